// ### hdl/sdcsm_blink.sv
// Square wave blink generator with equal on and off halves
`timescale 1ns/10ps
module sdcsm_blink #(
  parameter int unsigned HALF = 2,
  parameter int CNT_W = 27
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  output logic phase
);

  logic [CNT_W-1:0] cnt_reg;
  logic phase_reg;

  assign phase = phase_reg;

  // RL12 equal half periods
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_reg <= '0;
      phase_reg <= 1'b1;
    end
    else if (!run)
    begin
      // Restart lit so each pattern opens with a full on half
      cnt_reg <= '0;
      phase_reg <= 1'b1;
    end
    else if (cnt_reg == CNT_W'(HALF - 1))
    begin
      cnt_reg <= '0;
      phase_reg <= ~phase_reg;
    end
    else
    begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

endmodule : sdcsm_blink

// ### hdl/sdcsm_map.svh
// Register map, field positions, reset values and timing counts of the card slot monitor
`ifndef SDCSM_MAP_SVH
`define SDCSM_MAP_SVH

// Register byte offsets
`define SDCSM_OFF_STATUS 12'h000
`define SDCSM_OFF_CONTROL 12'h004
`define SDCSM_OFF_CAPACITY 12'h008
`define SDCSM_OFF_FREE 12'h00C

// Status fields
`define SDCSM_ST_MOUNTED 0
`define SDCSM_ST_BUSY 1
`define SDCSM_ST_WPROT 2
`define SDCSM_ST_PRESENT 3
`define SDCSM_ST_STATE_LSB 8
`define SDCSM_ST_STATE_W 3

// Control fields
`define SDCSM_CTL_UNMOUNT 0

// Reset values
`define SDCSM_RST_UNMOUNT 1'h0
`define SDCSM_RST_MB 16'h0000

// Largest supported card, 32 GB in megabytes
`define SDCSM_MAX_CAP_MB 16'h8000

// Timing
`define SDCSM_CLK_MHZ 250
`define SDCSM_SLOW_PERIOD_MS 1000
`define SDCSM_FAST_PERIOD_MS 100
`define SDCSM_SLOW_HALF_CYC ((`SDCSM_SLOW_PERIOD_MS * 1000 * `SDCSM_CLK_MHZ) / 2)
`define SDCSM_FAST_HALF_CYC ((`SDCSM_FAST_PERIOD_MS * 1000 * `SDCSM_CLK_MHZ) / 2)
`define SDCSM_BLINK_CNT_W 27

`endif

// ### hdl/sdcsm_pkg.sv
// Types shared by the card slot monitor and its surroundings
package sdcsm_pkg;

  typedef enum logic [2:0] {
    st_empty,
    st_ident,
    st_ready,
    st_access,
    st_unmount,
    st_unmounted,
    st_bad
  } sdcsm_state_t;

  // Program side transfer request, req is a one-cycle strobe
  typedef struct packed {
    logic req;
    logic write;
  } sdcsm_acc_req_t;

  typedef struct packed {
    logic done;
    logic refused;
  } sdcsm_acc_rsp_t;

  // Card engine answers, all one-cycle strobes with data
  typedef struct packed {
    logic ident_done;
    logic ident_ok;
    logic [15:0] capacity_mb;
    logic free_valid;
    logic [15:0] free_mb;
    logic xfer_done;
    logic flush_done;
  } sdcsm_eng_rsp_t;

  typedef struct packed {
    logic ident_start;
    logic xfer_start;
    logic xfer_write;
    logic flush;
  } sdcsm_eng_cmd_t;

endpackage : sdcsm_pkg

// ### hdl/sdcsm_top.sv
// Card slot status monitor: card state, status LED patterns and APB registers
`timescale 1ns/10ps
`include "sdcsm_map.svh"
////////////////////////////////////////////////////////////////////////////////
// Function
// RL1 - LED steady on while a recognised card idles ready, not safe to remove
// RL2 - LED slow blink, 1 s period, while identifying or unmounting
// RL3 - LED fast blink, 100 ms period, during any read or write transfer
// RL4 - LED dark when empty, unsupported card or unmounted on request
// RL5 - Mounted flag set when card usable, cleared when absent or unrecognised
// RL6 - Busy flag high for the whole of each card access
// RL7 - Unmount request stops access until the card is removed and reinserted
// RL8 - Capacity in megabytes up to 32 GB, zero when absent or unrecognised
// RL9 - Free space in megabytes, zero when absent or unrecognised
// RL10 - No write to a card whose write protect switch is set
// RL11 - Operator removes card only powered down or after unmount completes
// RL12 - Both blink patterns from clock counters, equal on and off halves
////////////////////////////////////////////////////////////////////////////////
module sdcsm_top #(
  parameter int unsigned SLOW_HALF = `SDCSM_SLOW_HALF_CYC,
  parameter int unsigned FAST_HALF = `SDCSM_FAST_HALF_CYC,
  parameter int CNT_W = `SDCSM_BLINK_CNT_W
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic card_present_n,
  input wire logic card_wprot,
  input wire sdcsm_pkg::sdcsm_acc_req_t acc_req,
  output sdcsm_pkg::sdcsm_acc_rsp_t acc_rsp,
  input wire sdcsm_pkg::sdcsm_eng_rsp_t eng_rsp,
  output sdcsm_pkg::sdcsm_eng_cmd_t eng_cmd,
  output logic card_mounted_flag,
  output logic card_busy_flag,
  output logic led
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [1:0] pin_meta_reg;
  logic [1:0] pin_sync_reg;
  logic present_s;
  logic wprot_s;
  logic present_d_reg;
  logic removed;

  sdcsm_pkg::sdcsm_state_t state_reg;
  sdcsm_pkg::sdcsm_eng_cmd_t cmd_reg;
  sdcsm_pkg::sdcsm_acc_rsp_t rsp_reg;

  logic card_unmount_request_reg;
  logic [15:0] card_capacity_mb_reg;
  logic [15:0] card_free_mb_reg;
  logic card_mounted_flag_reg;
  logic card_busy_flag_reg;

  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic apb_access;
  logic apb_commit;
  logic ctl_write;

  logic slow_run;
  logic fast_run;
  logic slow_phase;
  logic fast_phase;
  logic led_reg;
  logic ident_good;
  logic [31:0] status_word;

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign eng_cmd = cmd_reg;
  assign acc_rsp = rsp_reg;
  assign card_mounted_flag = card_mounted_flag_reg;
  assign card_busy_flag = card_busy_flag_reg;
  assign led = led_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Slot pins, two flops each before any use

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_meta_reg <= 2'h0;
      pin_sync_reg <= 2'h0;
    end
    else
    begin
      pin_meta_reg <= {card_wprot, ~card_present_n};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  assign present_s = pin_sync_reg[0];
  assign wprot_s = pin_sync_reg[1];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      present_d_reg <= 1'b0;
    end
    else
    begin
      present_d_reg <= present_s;
    end
  end

  // No debounce beyond the synchroniser; slot switch bounce restarts identify
  assign removed = present_d_reg & ~present_s;

  ////////////////////////////////////////////////////////////////////////////
  // Card state machine and engine commands

  // Cards beyond 32 GB or of zero size count as unsupported
  assign ident_good = eng_rsp.ident_ok &&
                      (eng_rsp.capacity_mb != 16'h0000) &&
                      (eng_rsp.capacity_mb <= `SDCSM_MAX_CAP_MB);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= sdcsm_pkg::st_empty;
      cmd_reg <= '0;
      rsp_reg <= '0;
    end
    else
    begin
      cmd_reg <= '0;
      rsp_reg <= '0;
      // RL10 write protect refusal
      if (acc_req.req && (state_reg != sdcsm_pkg::st_ready || card_unmount_request_reg ||
          (acc_req.write && wprot_s) || !present_s))
      begin
        rsp_reg.refused <= 1'b1;
      end
      if (!present_s)
      begin
        // Removal ends everything; a transfer in flight is answered refused
        if (state_reg == sdcsm_pkg::st_access)
        begin
          rsp_reg.refused <= 1'b1;
        end
        state_reg <= sdcsm_pkg::st_empty;
      end
      else
      begin
        case (state_reg)
          sdcsm_pkg::st_empty:
          begin
            state_reg <= sdcsm_pkg::st_ident;
            cmd_reg.ident_start <= 1'b1;
          end
          sdcsm_pkg::st_ident:
          begin
            // RL7 abandon identify
            if (card_unmount_request_reg)
            begin
              state_reg <= sdcsm_pkg::st_unmount;
              cmd_reg.flush <= 1'b1;
            end
            // RL5 recognise card
            else if (eng_rsp.ident_done)
            begin
              state_reg <= ident_good ? sdcsm_pkg::st_ready : sdcsm_pkg::st_bad;
            end
          end
          sdcsm_pkg::st_ready:
          begin
            // RL7 stop new access
            if (card_unmount_request_reg)
            begin
              state_reg <= sdcsm_pkg::st_unmount;
              cmd_reg.flush <= 1'b1;
            end
            // RL10 grant only allowed writes
            else if (acc_req.req && !(acc_req.write && wprot_s))
            begin
              state_reg <= sdcsm_pkg::st_access;
              cmd_reg.xfer_start <= 1'b1;
              cmd_reg.xfer_write <= acc_req.write;
            end
          end
          sdcsm_pkg::st_access:
          begin
            // RL6 access ends on done
            if (eng_rsp.xfer_done)
            begin
              rsp_reg.done <= 1'b1;
              if (card_unmount_request_reg)
              begin
                state_reg <= sdcsm_pkg::st_unmount;
                cmd_reg.flush <= 1'b1;
              end
              else
              begin
                state_reg <= sdcsm_pkg::st_ready;
              end
            end
          end
          sdcsm_pkg::st_unmount:
          begin
            if (eng_rsp.flush_done)
            begin
              state_reg <= sdcsm_pkg::st_unmounted;
            end
          end
          default:
          begin
            // RL7 wait for removal
            state_reg <= state_reg;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program visible flags

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      card_mounted_flag_reg <= 1'b0;
      card_busy_flag_reg <= 1'b0;
    end
    else
    begin
      // RL5 mounted flag
      card_mounted_flag_reg <= (state_reg == sdcsm_pkg::st_ready) ||
                               (state_reg == sdcsm_pkg::st_access);
      // RL6 busy flag
      card_busy_flag_reg <= (state_reg == sdcsm_pkg::st_access);
    end
  end

  // Unmount request: software owns it, removal clears it so a fresh card mounts
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      card_unmount_request_reg <= `SDCSM_RST_UNMOUNT;
    end
    else if (ctl_write)
    begin
      card_unmount_request_reg <= pwdata[`SDCSM_CTL_UNMOUNT];
    end
    // RL7 rearm on removal
    else if (removed || state_reg == sdcsm_pkg::st_empty)
    begin
      card_unmount_request_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capacity and free space

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      card_capacity_mb_reg <= `SDCSM_RST_MB;
      card_free_mb_reg <= `SDCSM_RST_MB;
    end
    // RL8 zero when absent
    else if (!present_s || state_reg == sdcsm_pkg::st_empty || state_reg == sdcsm_pkg::st_bad ||
             state_reg == sdcsm_pkg::st_unmounted)
    begin
      card_capacity_mb_reg <= `SDCSM_RST_MB;
      card_free_mb_reg <= `SDCSM_RST_MB;
    end
    else if (state_reg == sdcsm_pkg::st_ident)
    begin
      // RL8 capacity on recognition
      if (eng_rsp.ident_done && ident_good && !card_unmount_request_reg)
      begin
        card_capacity_mb_reg <= eng_rsp.capacity_mb;
        card_free_mb_reg <= eng_rsp.free_mb;
      end
    end
    // RL9 free space updates
    else if (eng_rsp.free_valid)
    begin
      card_free_mb_reg <= eng_rsp.free_mb;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status LED

  // RL2 slow pattern
  assign slow_run = (state_reg == sdcsm_pkg::st_ident) || (state_reg == sdcsm_pkg::st_unmount);
  // RL3 fast pattern
  assign fast_run = (state_reg == sdcsm_pkg::st_access);

  sdcsm_blink #(
    .HALF(SLOW_HALF),
    .CNT_W(CNT_W)
  ) u_slow (
    .pclk(pclk),
    .presetn(presetn),
    .run(slow_run),
    .phase(slow_phase)
  );

  sdcsm_blink #(
    .HALF(FAST_HALF),
    .CNT_W(CNT_W)
  ) u_fast (
    .pclk(pclk),
    .presetn(presetn),
    .run(fast_run),
    .phase(fast_phase)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      led_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        // RL1 steady on
        sdcsm_pkg::st_ready: led_reg <= 1'b1;
        sdcsm_pkg::st_ident: led_reg <= slow_phase;
        sdcsm_pkg::st_unmount: led_reg <= slow_phase;
        sdcsm_pkg::st_access: led_reg <= fast_phase;
        // RL4 dark otherwise
        default: led_reg <= 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave, one wait state so every answer comes from a flop

  assign apb_access = psel && penable;
  assign apb_commit = apb_access && pready_reg;
  assign ctl_write = apb_commit && pwrite && pstrb[0] && (paddr == `SDCSM_OFF_CONTROL);

  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[`SDCSM_ST_MOUNTED] = card_mounted_flag_reg;
    status_word[`SDCSM_ST_BUSY] = card_busy_flag_reg;
    status_word[`SDCSM_ST_WPROT] = wprot_s;
    status_word[`SDCSM_ST_PRESENT] = present_s;
    status_word[`SDCSM_ST_STATE_LSB +: `SDCSM_ST_STATE_W] = state_reg;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end
    else if (apb_access && !pready_reg)
    begin
      pready_reg <= 1'b1;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      if (paddr == `SDCSM_OFF_STATUS)
      begin
        if (!pwrite)
        begin
          prdata_reg <= status_word;
        end
      end
      else if (paddr == `SDCSM_OFF_CONTROL)
      begin
        if (!pwrite)
        begin
          prdata_reg <= {31'h0000_0000, card_unmount_request_reg};
        end
      end
      else if (paddr == `SDCSM_OFF_CAPACITY)
      begin
        if (!pwrite)
        begin
          prdata_reg <= {16'h0000, card_capacity_mb_reg};
        end
      end
      else if (paddr == `SDCSM_OFF_FREE)
      begin
        if (!pwrite)
        begin
          prdata_reg <= {16'h0000, card_free_mb_reg};
        end
      end
      else
      begin
        // Unmapped address answers with an error and zero data
        pslverr_reg <= 1'b1;
      end
    end
    else
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end
  end

endmodule : sdcsm_top

// ### test/sdcsm_card_model.sv
// Behavioural card engine answering the monitor's commands
`timescale 1ns/10ps
module sdcsm_card_model #(
  parameter int ID_CYC = 20,
  parameter int XF_CYC = 12
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire sdcsm_pkg::sdcsm_eng_cmd_t eng_cmd,
  input wire logic [15:0] cap,
  output sdcsm_pkg::sdcsm_eng_rsp_t eng_rsp
);
  int id_c;
  int xf_c;
  int fl_c;
  logic [15:0] fr;
  assign fr = cap >> 1;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      id_c <= 0;
      xf_c <= 0;
      fl_c <= 0;
      eng_rsp <= '0;
    end
    else
    begin
      // Data lines carry junk between answers, never the last good value
      eng_rsp <= {2'b00, ~cap, 1'b0, ~fr, 2'b00};
      id_c <= eng_cmd.ident_start ? ID_CYC : id_c - int'(id_c > 0);
      xf_c <= eng_cmd.xfer_start ? XF_CYC : xf_c - int'(xf_c > 0);
      fl_c <= eng_cmd.flush ? ID_CYC : fl_c - int'(fl_c > 0);
      if (id_c == 1)
      begin
        eng_rsp.ident_done <= 1'b1;
        eng_rsp.ident_ok <= |cap;
        eng_rsp.capacity_mb <= cap;
        eng_rsp.free_valid <= 1'b1;
        eng_rsp.free_mb <= fr;
      end
      if (xf_c == 1)
        eng_rsp.xfer_done <= 1'b1;
      if (fl_c == 1)
        eng_rsp.flush_done <= 1'b1;
    end
  end
endmodule : sdcsm_card_model

// ### test/sdcsm_checker.sv
// Port checks of the card slot monitor
`timescale 1ns/10ps
`include "sdcsm_map.svh"
module sdcsm_checker #(
  parameter int unsigned SLOW_HALF = 8,
  parameter int unsigned FAST_HALF = 2
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic card_present_n,
  input wire logic card_wprot,
  input wire sdcsm_pkg::sdcsm_acc_req_t acc_req,
  input wire sdcsm_pkg::sdcsm_acc_rsp_t acc_rsp,
  input wire sdcsm_pkg::sdcsm_eng_rsp_t eng_rsp,
  input wire sdcsm_pkg::sdcsm_eng_cmd_t eng_cmd,
  input wire logic card_mounted_flag,
  input wire logic card_busy_flag,
  input wire logic led
);
  logic [31:0] run;
  logic fast_run;
  logic slow_run;
  logic slow_now;
  assign slow_now = !card_mounted_flag && !card_busy_flag && !card_present_n;
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Length of each LED level; a run is judged only if it began inside the same blink mode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run <= 32'h0;
      fast_run <= 1'b0;
      slow_run <= 1'b0;
    end
    else if ($changed(led))
    begin
      run <= 32'h1;
      fast_run <= card_busy_flag;
      slow_run <= slow_now;
    end
    else
    begin
      run <= run + 32'h1;
      fast_run <= fast_run && card_busy_flag;
      slow_run <= slow_run && slow_now;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  led_dark_a: assert property (card_present_n [*6] |-> !card_mounted_flag && !led)
    else $error("flag or LED on with slot empty");
  mount_set_a: assert property (eng_rsp.ident_done && eng_rsp.ident_ok && !card_present_n
    && eng_rsp.capacity_mb inside {[16'h0001:16'h8000]} |-> ##2 card_mounted_flag && led)
    else $error("usable card not mounted");
  busy_set_a: assert property (eng_cmd.xfer_start |=> card_busy_flag)
    else $error("busy flag late");
  busy_clear_a: assert property (acc_rsp.done |=> !card_busy_flag)
    else $error("busy flag stuck");
  no_prot_write_a: assert property (card_wprot [*6] |-> !(eng_cmd.xfer_start && eng_cmd.xfer_write))
    else $error("write to protected card");
  size_zero_a: assert property ((card_present_n [*6] ##0 (psel && penable && pready && !pwrite
    && (paddr == `SDCSM_OFF_CAPACITY || paddr == `SDCSM_OFF_FREE))) |-> prdata == 32'h0)
    else $error("size nonzero with slot empty");
  unmount_stop_a: assert property (psel && penable && pready && pwrite && paddr == `SDCSM_OFF_CONTROL
    && pwdata[0] && pstrb[0] && card_mounted_flag && !card_busy_flag |-> ##[1:4] !card_mounted_flag)
    else $error("unmount ignored");
  fast_blink_a: assert property ($changed(led) && fast_run && card_busy_flag |-> run == FAST_HALF)
    else $error("fast blink half wrong");
  slow_blink_a: assert property ($rose(led) && slow_run && slow_now |-> run == SLOW_HALF)
    else $error("slow blink half wrong");
  cover property (eng_cmd.xfer_start && eng_cmd.xfer_write);
  cover property (acc_rsp.refused);
  cover property (eng_cmd.flush);
endmodule : sdcsm_checker
bind sdcsm_top sdcsm_checker #(.SLOW_HALF(SLOW_HALF), .FAST_HALF(FAST_HALF)) i_sdcsm_checker (.*);

// ### test/sdcsm_top_test.sv
// Self-checking bench of the card slot monitor
`timescale 1ns/10ps
`include "sdcsm_map.svh"
module sdcsm_top_test;
  logic pclk, presetn, psel, penable, pwrite, card_present_n, card_wprot, pready, pslverr, ok;
  logic card_mounted_flag, card_busy_flag, led;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [15:0] cap;
  sdcsm_pkg::sdcsm_acc_req_t acc_req;
  sdcsm_pkg::sdcsm_acc_rsp_t acc_rsp;
  sdcsm_pkg::sdcsm_eng_rsp_t eng_rsp;
  sdcsm_pkg::sdcsm_eng_cmd_t eng_cmd;
  logic [32:0] rd_q[$];
  logic [1:0] ac_q[$];
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;
  integer seed = 32'hC4B04323;
  sdcsm_top #(.SLOW_HALF(8), .FAST_HALF(2)) i_sdcsm_top (.*);
  sdcsm_card_model i_sdcsm_card_model (.*);
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict;
    // Expectations never answered count together as one mismatch
    if (rd_q.size() != 0 || ac_q.size() != 0)
      err_count++;
    $display("mismatches %0d of %0d checks", err_count, tests_run);
    if (err_count == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick
  // APB master: hold the request until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    // One edge first, so back to back calls never set psel twice in one step
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk iff pready === 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    rd_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic strobe(input logic w);
    acc_req <= {1'b1, w};
    tick(1);
    acc_req <= 2'b00;
  endtask : strobe
  task automatic acc(input logic w, input logic [1:0] e);
    ac_q.push_back(e);
    strobe(w);
    @(posedge pclk iff acc_rsp !== 2'b00);
  endtask : acc
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge pclk)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite)
      check({pslverr, prdata}, rd_q.pop_front());
    if (presetn && acc_rsp !== 2'b00)
      check({31'h0, acc_rsp}, {31'h0, ac_q.pop_front()});
    cyc++;
    if (cyc == 5000)
    begin
      err_count++;
      give_verdict();
    end
  end
  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, card_wprot, acc_req, cap} = '0;
    pstrb = 4'hF;
    card_present_n = 1'b1;
    tick(3);
    presetn <= 1'b1;
    rd(`SDCSM_OFF_CAPACITY, 33'h0);
    rd(`SDCSM_OFF_FREE, 33'h0);
    rd(`SDCSM_OFF_STATUS, 33'h0);
    rd(12'h010, 33'h1_0000_0000);
    apb(1'b1, `SDCSM_OFF_CAPACITY, 32'hFFFF);
    rd(`SDCSM_OFF_CAPACITY, 33'h0);
    acc(1'b0, 2'b01);
    // Random size, then the largest and one past the largest size
    for (int k = 0; k < 3; k++)
    begin
      ok = k < 2;
      cap <= (k == 0) ? (16'($random(seed)) & 16'h7FFF) + 16'h1 : 16'h7FFF + 16'(k);
      card_present_n <= 1'b0;
      @(posedge pclk iff eng_rsp.ident_done);
      tick(3);
      check({32'h0, card_mounted_flag}, {32'h0, ok});
      check({32'h0, led}, {32'h0, ok});
      rd(`SDCSM_OFF_CAPACITY, ok ? {17'h0, cap} : 33'h0);
      rd(`SDCSM_OFF_FREE, ok ? {17'h0, cap >> 1} : 33'h0);
      card_present_n <= 1'b1;
      tick(8);
    end
    // Last loop left an oversized card; insert a supported one
    cap <= (16'($random(seed)) & 16'h3FFF) + 16'h1;
    card_present_n <= 1'b0;
    @(posedge pclk iff card_mounted_flag === 1'b1);
    rd(`SDCSM_OFF_STATUS, 33'h209);
    for (int k = 0; k < 4; k++)
    begin
      card_wprot <= k[1];
      tick(4);
      acc(k[0], (k == 3) ? 2'b01 : 2'b10);
    end
    card_wprot <= 1'b0;
    ac_q.push_back(2'b01);
    ac_q.push_back(2'b10);
    strobe(1'b0);
    tick(3);
    strobe(1'b0);
    @(posedge pclk iff acc_rsp.done === 1'b1);
    // Unmount write without its low byte lane must be ignored
    pstrb <= 4'($random(seed)) & 4'hE;
    apb(1'b1, `SDCSM_OFF_CONTROL, 32'h1);
    pstrb <= 4'hF;
    rd(`SDCSM_OFF_CONTROL, 33'h0);
    apb(1'b1, `SDCSM_OFF_CONTROL, 32'h1);
    rd(`SDCSM_OFF_CONTROL, 33'h1);
    @(posedge pclk iff eng_rsp.flush_done);
    tick(3);
    check({32'h0, led}, 33'h0);
    rd(`SDCSM_OFF_CAPACITY, 33'h0);
    acc(1'b0, 2'b01);
    card_present_n <= 1'b1;
    tick(6);
    rd(`SDCSM_OFF_CONTROL, 33'h0);
    card_present_n <= 1'b0;
    @(posedge pclk iff card_mounted_flag === 1'b1);
    // Pulling the card mid-write must refuse the transfer
    ac_q.push_back(2'b01);
    strobe(1'b1);
    tick(4);
    card_present_n <= 1'b1;
    @(posedge pclk iff acc_rsp.refused === 1'b1);
    presetn <= 1'b0;
    tick(2);
    presetn <= 1'b1;
    rd(`SDCSM_OFF_STATUS, 33'h0);
    tick(2);
    give_verdict();
  end
endmodule : sdcsm_top_test
